// [hdl/etb_pkg.sv]
// Purpose: shared constants, register map and carriers of the elapsed timer bank
// Assumes: 20 MHz clk, APB slave with 32-bit data
// Notes: time value held as packed BCD-free binary fields
package etb_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int TICK_HZ = 100;
   localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
   localparam int NUM_TIMERS = 16;
   localparam int MSG_W = 8;
   localparam logic [13:0] MAX_HOURS = 14'h270f;
   localparam logic [5:0] MAX_MINSEC = 6'h3b;
   localparam logic [6:0] MAX_HUND = 7'h63;
   // register map, byte addresses; the timer index sits in addr[9:6]
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_VALUE = 12'h004;
   localparam logic [11:0] REG_TRIG = 12'h008;
   localparam logic [11:0] REG_MSG = 12'h00c;
   localparam logic [11:0] REG_STATUS = 12'h400;
   localparam logic [11:0] REG_CLEAR = 12'h404;
   localparam logic [11:0] REG_ENABLE = 12'h408;
   localparam logic [11:0] REG_REQ = 12'h40c;
   localparam logic [11:0] REG_KEEP = 12'h410;
   localparam logic [11:0] REG_DIR = 12'h414;
   localparam logic [11:0] REG_RUN = 12'h418;
   localparam logic [11:0] REG_OVF = 12'h41c;
   // control word bits: write-enable (select) bit paired with a value bit; clear-overflow and zero are lone strobes, bit 16 reads the flag
   localparam int C_RUN = 0;
   localparam int C_RUN_SEL = 1;
   localparam int C_DIR = 2;
   localparam int C_DIR_SEL = 3;
   localparam int C_TEN = 4;
   localparam int C_TEN_SEL = 5;
   localparam int C_AUTO = 6;
   localparam int C_AUTO_SEL = 7;
   localparam int C_KEEP = 8;
   localparam int C_KEEP_SEL = 9;
   localparam int C_CLR_OVF = 10;
   localparam int C_ZERO = 11;
   localparam int C_OVF = 16;
   typedef struct packed
   {
      logic [13:0] hours;
      logic [5:0] minutes;
      logic [5:0] seconds;
      logic [6:0] hundredths;
   } etb_time_s;
   typedef struct packed
   {
      logic run;
      logic down;
      logic trigEn;
      logic autoRestart;
      logic keep;
   } etb_cfg_s;
   typedef enum logic [1:0] {ETB_IDLE, ETB_ACCESS} etb_apb_e;
endpackage

// [hdl/etb_elapsed_timer_bank.sv]
// Purpose: sixteen elapsed timers with preset, wrap flags and match triggers, on APB
// Assumes: single 20 MHz clock, synchronous active-high reset
// Notes: kept timers survive srst; a true power-up is the initial reset with keep cleared
// Operation
// - sixteen timers, each with its own configuration and value
// - all timers advance together every hundredth tick according to run and direction
// - keep mode preserves configuration, run state and value through reset
// - clear mode on reset stops the timer and zeroes its value
// - run bit set counts, cleared holds the value
// - direction bit picks up or down; changing it keeps running and value
// - any preset value up to 8191:59:59.99 is loadable; the top hours bit is always written as zero
// - counting past either end wraps and sets a sticky overflow flag
// - overflow flag stays set until an explicit clear request
// - enabled trigger matching the value requests the timer's message number
// - single match clears trigger enable after the request, timer keeps counting
// - auto restart match zeroes the value, keeps running and trigger enabled
// - trigger compare value loadable up to 8191:59:59.99; the top hours bit is always written as zero
// - each timer holds its own writable message number, duplicates allowed
// - an update changes only the selected fields
// - current count is readable at any moment
module etb_elapsed_timer_bank
   import etb_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic trigValid,
   output logic [MSG_W-1:0] trigMsg,
   output logic [3:0] trigTimer
);
   etb_time_s value [NUM_TIMERS];
   etb_time_s trigVal [NUM_TIMERS];
   logic [MSG_W-1:0] msgNum [NUM_TIMERS];
   etb_cfg_s cfg [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] ovf;
   logic [NUM_TIMERS-1:0] status;
   logic [NUM_TIMERS-1:0] enable;
   logic [NUM_TIMERS-1:0] pending;
   logic [NUM_TIMERS-1:0] hit;
   logic [23:0] divCnt;
   logic tick;
   etb_apb_e apbState;
   logic wrStb;
   logic [3:0] sel;
   logic [11:0] regOff;
   logic [31:0] next_prdata;
   logic next_err;

   // hundredth-second enable; a divider keeps a single clock domain
   always_ff @(posedge clk)
   begin
      if (srst || divCnt == 24'(TICK_DIV - 1))
         divCnt <= '0;
      else
         divCnt <= divCnt + 24'h000001;
   end
   always_ff @(posedge clk)
   begin
      tick <= !srst && divCnt == 24'(TICK_DIV - 1);
   end

   // apb: one wait state, access answered in the second access cycle
   assign sel = paddr[9:6];
   // full low offset, so a misaligned address matches no timer register and is ignored
   assign regOff = (paddr[11] || paddr[10]) ? 12'h000 : {6'h00, paddr[5:0]};
   assign wrStb = psel && penable && pwrite && pready;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         apbState <= ETB_IDLE;
         pready <= 1'b0;
      end
      else
      begin
         unique case (apbState)
            ETB_IDLE:
            begin
               pready <= 1'b0;
               if (psel && penable)
               begin
                  apbState <= ETB_ACCESS;
                  pready <= 1'b1;
               end
            end
            ETB_ACCESS:
            begin
               apbState <= ETB_IDLE;
               pready <= 1'b0;
            end
         endcase
      end
   end

   // read mux; the live count is visible at any moment
   always_comb
   begin
      next_prdata = '0;
      next_err = 1'b0;
      if (paddr[10])
      begin
         unique case (paddr)
            REG_STATUS: next_prdata = {16'h0000, status};
            REG_CLEAR: next_prdata = '0;
            REG_ENABLE: next_prdata = {16'h0000, enable};
            REG_REQ: next_prdata = {16'h0000, pending};
            REG_OVF: next_prdata = {16'h0000, ovf};
            default: next_err = 1'b1;
         endcase
      end
      else if (paddr[11] || paddr[1:0] != 2'b00)
         next_err = 1'b1;
      else
      begin
         unique case (regOff)
            REG_CTRL: next_prdata = {15'h0000, ovf[sel], 7'h00, cfg[sel].keep, 1'b0, cfg[sel].autoRestart,
                                     1'b0, cfg[sel].trigEn, 1'b0, cfg[sel].down, 1'b0, cfg[sel].run};
            // the top hours bit does not fit the 32-bit word and reads as dropped
            REG_VALUE: next_prdata = value[sel][31:0];
            REG_TRIG: next_prdata = trigVal[sel][31:0];
            REG_MSG: next_prdata = {{(32-MSG_W){1'b0}}, msgNum[sel]};
            default: next_err = 1'b1;
         endcase
      end
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else if (apbState == ETB_IDLE && psel && penable)
      begin
         prdata <= pwrite ? 32'h00000000 : next_prdata;
         pslverr <= next_err;
      end
   end

   // one timer per loop pass; each timer's logic is independent
   for (genvar i = 0; i < NUM_TIMERS; i++)
   begin : g_timer
      logic wrCtrl;
      logic wrVal;
      logic wrTrig;
      logic wrMsg;
      logic match;
      logic run;
      logic down;
      logic wrapUp;
      logic wrapDn;
      etb_time_s up;
      etb_time_s dn;
      etb_time_s t;
      assign wrCtrl = wrStb && !paddr[10] && !paddr[11] && sel == 4'(i) && regOff == REG_CTRL;
      assign wrVal = wrStb && !paddr[10] && !paddr[11] && sel == 4'(i) && regOff == REG_VALUE;
      assign wrTrig = wrStb && !paddr[10] && !paddr[11] && sel == 4'(i) && regOff == REG_TRIG;
      assign wrMsg = wrStb && !paddr[10] && !paddr[11] && sel == 4'(i) && regOff == REG_MSG;
      assign run = (wrCtrl && pwdata[C_RUN_SEL]) ? pwdata[C_RUN] : cfg[i].run;
      assign down = (wrCtrl && pwdata[C_DIR_SEL]) ? pwdata[C_DIR] : cfg[i].down;
      assign match = cfg[i].trigEn && value[i] == trigVal[i];
      assign hit[i] = match && tick && run;
      assign t = value[i];
      assign wrapUp = t == {MAX_HOURS, MAX_MINSEC, MAX_MINSEC, MAX_HUND};
      assign wrapDn = t == '0;
      // incrementer and decrementer with sixty carry on seconds and minutes
      always_comb
      begin
         up = t;
         dn = t;
         if (t.hundredths != MAX_HUND) up.hundredths = t.hundredths + 7'h01;
         else
         begin
            up.hundredths = '0;
            if (t.seconds != MAX_MINSEC) up.seconds = t.seconds + 6'h01;
            else
            begin
               up.seconds = '0;
               if (t.minutes != MAX_MINSEC) up.minutes = t.minutes + 6'h01;
               else
               begin
                  up.minutes = '0;
                  up.hours = (t.hours == MAX_HOURS) ? 14'h0000 : t.hours + 14'h0001;
               end
            end
         end
         if (t.hundredths != 7'h00) dn.hundredths = t.hundredths - 7'h01;
         else
         begin
            dn.hundredths = MAX_HUND;
            if (t.seconds != 6'h00) dn.seconds = t.seconds - 6'h01;
            else
            begin
               dn.seconds = MAX_MINSEC;
               if (t.minutes != 6'h00) dn.minutes = t.minutes - 6'h01;
               else
               begin
                  dn.minutes = MAX_MINSEC;
                  dn.hours = (t.hours == 14'h0000) ? MAX_HOURS : t.hours - 14'h0001;
               end
            end
         end
      end
      // value: preset beats match restart, which beats counting
      always_ff @(posedge clk)
      begin
         if (srst)
         begin
            if (!cfg[i].keep)
               value[i] <= '0;
         end
         else if (wrVal)
            value[i] <= {1'b0, pwdata};
         else if (wrCtrl && pwdata[C_ZERO])
            value[i] <= '0;
         else if (hit[i] && cfg[i].autoRestart)
            value[i] <= '0;
         else if (tick && run)
            value[i] <= down ? dn : up;
      end
      // configuration fields written only when selected, except trigger enable, which a single match also clears; reset honours keep
      always_ff @(posedge clk)
      begin
         if (srst)
         begin
            if (!cfg[i].keep)
               cfg[i] <= '0;
         end
         else
         begin
            cfg[i].run <= run;
            cfg[i].down <= down;
            if (wrCtrl && pwdata[C_AUTO_SEL]) cfg[i].autoRestart <= pwdata[C_AUTO];
            if (wrCtrl && pwdata[C_KEEP_SEL]) cfg[i].keep <= pwdata[C_KEEP];
            if (hit[i] && !cfg[i].autoRestart)
               cfg[i].trigEn <= 1'b0;
            else if (wrCtrl && pwdata[C_TEN_SEL])
               cfg[i].trigEn <= pwdata[C_TEN];
         end
      end
      always_ff @(posedge clk)
      begin
         if (srst && !cfg[i].keep)
         begin
            trigVal[i] <= '0;
            msgNum[i] <= '0;
         end
         else if (!srst)
         begin
            if (wrTrig) trigVal[i] <= {1'b0, pwdata};
            if (wrMsg) msgNum[i] <= pwdata[MSG_W-1:0];
         end
      end
      // sticky wrap flag; a wrap in the clearing cycle wins
      always_ff @(posedge clk)
      begin
         if (srst)
         begin
            if (!cfg[i].keep) ovf[i] <= 1'b0;
         end
         else if (tick && run && !wrVal && !(hit[i] && cfg[i].autoRestart) && (down ? wrapDn : wrapUp))
            ovf[i] <= 1'b1;
         else if (wrCtrl && pwdata[C_CLR_OVF])
            ovf[i] <= 1'b0;
      end
   end

   // request queue: one pending bit per timer, lowest index issued first
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pending <= '0;
         trigValid <= 1'b0;
         trigMsg <= '0;
         trigTimer <= '0;
      end
      else
      begin
         logic [NUM_TIMERS-1:0] p;
         logic found;
         p = pending | hit;
         found = 1'b0;
         trigValid <= 1'b0;
         for (int k = 0; k < NUM_TIMERS; k++)
         begin
            if (!found && p[k])
            begin
               found = 1'b1;
               p[k] = 1'b0;
               trigValid <= 1'b1;
               trigMsg <= msgNum[k];
               trigTimer <= 4'(k);
            end
         end
         pending <= p;
      end
   end

   // interrupt status: match events only; set wins over clear
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         status <= '0;
         enable <= '0;
         irq <= 1'b0;
      end
      else
      begin
         status <= (status & ~((wrStb && paddr == REG_CLEAR) ? pwdata[15:0] : 16'h0000)) | hit;
         if (wrStb && paddr == REG_ENABLE)
            enable <= pwdata[15:0];
         irq <= |(status & enable);
      end
   end

   // assertions
   property p_tick_hold;
      @(posedge clk) disable iff (srst)
      !tick && !wrStb |=> value[0] == $past(value[0]);
   endproperty
   a_tick_hold: assert property (p_tick_hold) else $error("timer changed without tick or write");
   property p_stop_hold;
      @(posedge clk) disable iff (srst)
      !cfg[1].run && !wrStb |=> value[1] == $past(value[1]);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped timer moved");
   property p_wrap_up;
      @(posedge clk) disable iff (srst)
      tick && cfg[2].run && !cfg[2].down && !wrStb && !hit[2] && g_timer[2].wrapUp |=> value[2] == '0 && ovf[2];
   endproperty
   a_wrap_up: assert property (p_wrap_up) else $error("upward wrap wrong");
   property p_ovf_sticky;
      @(posedge clk) disable iff (srst)
      ovf[3] && !wrStb |=> ovf[3];
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
   sequence s_hit0;
      hit[0] && !wrStb && !cfg[0].autoRestart;
   endsequence
   property p_single;
      @(posedge clk) disable iff (srst)
      s_hit0 |=> !cfg[0].trigEn && cfg[0].run;
   endproperty
   a_single: assert property (p_single) else $error("single match left trigger on");
   property p_restart;
      @(posedge clk) disable iff (srst)
      hit[4] && !wrStb && cfg[4].autoRestart |=> value[4] == '0 && cfg[4].trigEn;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not zero");
   property p_request;
      @(posedge clk) disable iff (srst)
      hit[0] |=> trigValid && trigTimer == 4'h0;
   endproperty
   a_request: assert property (p_request) else $error("match produced no request");
   property p_clear;
      @(posedge clk) !cfg[5].keep && srst |=> value[5] == '0 && !cfg[5].run;
   endproperty
   a_clear: assert property (p_clear) else $error("clear mode survived reset");
   property p_keep;
      @(posedge clk) cfg[6].keep && srst |=> value[6] == $past(value[6]) && cfg[6].run == $past(cfg[6].run);
   endproperty
   a_keep: assert property (p_keep) else $error("kept timer lost state");
   property p_apb;
      @(posedge clk) disable iff (srst)
      psel && penable && !pready |=> pready;
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer late");
endmodule

// [dv/etb_elapsed_timer_bank_test.sv]
// Purpose: self-checking bench of the elapsed timer bank, driven over APB
// Assumes: TICK_DIV of 20, so one hundredth is 20 clocks; a poll read lasts 4 clocks
// Notes: hours above 8191 cannot pass a 32-bit word, so presets stay at or below that
module etb_elapsed_timer_bank_test
   import etb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TD = 20;
   logic clk, srst, psel, penable, pwrite, pready, pslverr, irq, trigValid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [MSG_W-1:0] trigMsg;
   logic [3:0] trigTimer;
   logic [11:0] trq[$];
   int nMismatch = 0;
   int testsRun = 0;

   etb_elapsed_timer_bank #(.TICK_DIV(TD)) u_etb_elapsed_timer_bank (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .trigValid(trigValid), .trigMsg(trigMsg), .trigTimer(trigTimer));

   // 20 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // record every request pulse so none is lost while a bus cycle runs
   always @(posedge clk)
      if (trigValid === 1'b1) trq.push_back({trigTimer, trigMsg});

   function automatic logic [31:0] tv(int h, int m, int s, int c);
      return {h[12:0], m[5:0], s[5:0], c[6:0]};
   endfunction

   function automatic logic [11:0] ta(int i, logic [11:0] r);
      return r | 12'({i[3:0], 6'h00});
   endfunction

   task automatic results();
      $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
      if (nMismatch == 0 && testsRun > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic hang(string what);
      nMismatch++;
      $display("[FAIL] %s expected done seen timeout", what);
      results();
   endtask

   // one transfer: setup, access held until pready, then a released cycle
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, output logic [31:0] rdat, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) hang("apb ready");
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(logic [11:0] a, logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, d, x, e);
   endtask

   task automatic rd(logic [11:0] a, output logic [31:0] v);
      logic e;
      apb(1'b0, a, 32'h0, v, e);
   endtask

   // polls faster than a tick, so the first change seen is a single step
   task automatic waitChange(logic [11:0] a, logic [31:0] old, output logic [31:0] v);
      int n;
      n = 0;
      do
      begin
         rd(a, v);
         n++;
      end
      while (v === old && n < 200);
      if (v === old) hang("value change");
   endtask

   task automatic waitTrig(int k);
      int n;
      n = 0;
      while (trq.size() < k && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      if (trq.size() < k) hang("trigger request");
   endtask

   task automatic doReset();
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
   endtask

   task automatic tPreset();
      logic [31:0] v;
      wr(ta(1, REG_VALUE), tv(8191, 59, 59, 99));
      rd(ta(1, REG_VALUE), v);
      check("preset value", v, tv(8191, 59, 59, 99));
      repeat (45) @(posedge clk);
      rd(ta(1, REG_VALUE), v);
      check("stopped value", v, tv(8191, 59, 59, 99));
      wr(ta(1, REG_TRIG), tv(8191, 59, 59, 99));
      rd(ta(1, REG_TRIG), v);
      check("trigger value", v, tv(8191, 59, 59, 99));
      wr(ta(1, REG_CTRL), 32'h0000_0015);
      rd(ta(1, REG_CTRL), v);
      check("unselected ctrl", v, 32'h0);
      wr(ta(1, REG_CTRL), 32'h0000_0800);
      rd(ta(1, REG_VALUE), v);
      check("zeroed value", v, 32'h0);
      $display("preset test done");
   endtask

   task automatic tWrap();
      logic [31:0] v, v1;
      wr(ta(2, REG_VALUE), tv(0, 59, 59, 99));
      wr(ta(2, REG_CTRL), 32'h3);
      waitChange(ta(2, REG_VALUE), tv(0, 59, 59, 99), v);
      check("carry", v, tv(1, 0, 0, 0));
      wr(ta(2, REG_CTRL), 32'h2);
      wr(ta(2, REG_VALUE), 32'h0);
      wr(ta(2, REG_CTRL), 32'hf);
      // 9999 hours loses its top bit in the read word
      waitChange(ta(2, REG_VALUE), 32'h0, v);
      wr(ta(2, REG_CTRL), 32'h2);
      check("down wrap", v, tv(1807, 59, 59, 99));
      repeat (45) @(posedge clk);
      rd(ta(2, REG_VALUE), v);
      check("held at max", v, tv(1807, 59, 59, 99));
      rd(ta(2, REG_CTRL), v);
      check("underflow ctrl", v, 32'h0001_0004);
      rd(REG_OVF, v);
      check("overflow reg", v & 32'h4, 32'h4);
      wr(ta(2, REG_CTRL), 32'h8);
      rd(ta(2, REG_CTRL), v);
      check("flag sticky", v, 32'h0001_0000);
      wr(ta(2, REG_CTRL), 32'h3);
      waitChange(ta(2, REG_VALUE), tv(1807, 59, 59, 99), v);
      check("up wrap", v, 32'h0);
      wr(ta(2, REG_CTRL), 32'h400);
      rd(ta(2, REG_CTRL), v);
      check("flag cleared", v, 32'h1);
      wr(ta(2, REG_CTRL), 32'h2);
      wr(ta(2, REG_VALUE), tv(0, 0, 10, 50));
      wr(ta(2, REG_CTRL), 32'h3);
      wr(ta(2, REG_CTRL), 32'hc);
      rd(ta(2, REG_CTRL), v);
      check("dir change runs", v, 32'h5);
      rd(ta(2, REG_VALUE), v1);
      waitChange(ta(2, REG_VALUE), v1, v);
      check("counts down", v, v1 - 32'h1);
      wr(ta(2, REG_CTRL), 32'h2);
      $display("wrap test done");
   endtask

   task automatic tTrig();
      logic [31:0] v;
      trq.delete();
      for (int i = 3; i < 5; i++)
      begin
         wr(ta(i, REG_VALUE), 32'h0);
         wr(ta(i, REG_TRIG), tv(0, 0, 0, 3));
         wr(ta(i, REG_MSG), 32'h5a);
      end
      wr(ta(3, REG_CTRL), 32'h33);
      wr(ta(4, REG_CTRL), 32'h33);
      waitTrig(2);
      check("first request", 32'(trq[0]), 32'h35a);
      check("second request", 32'(trq[1]), 32'h45a);
      rd(ta(3, REG_CTRL), v);
      check("single match ctrl", v, 32'h1);
      rd(ta(3, REG_VALUE), v);
      waitChange(ta(3, REG_VALUE), v, v);
      rd(REG_STATUS, v);
      check("status set", v & 32'h18, 32'h18);
      wr(REG_ENABLE, 32'h10);
      repeat (2) @(posedge clk);
      check("irq raised", 32'(irq), 32'h1);
      // status is read-only: a write must not clear it
      wr(REG_STATUS, 32'h0);
      wr(REG_CLEAR, 32'h8);
      rd(REG_STATUS, v);
      check("status clear", v & 32'h18, 32'h10);
      wr(REG_ENABLE, 32'h8);
      repeat (2) @(posedge clk);
      check("irq masked", 32'(irq), 32'h0);
      wr(REG_CLEAR, 32'h10);
      wr(ta(3, REG_CTRL), 32'h2);
      wr(ta(4, REG_CTRL), 32'h2);
      $display("trigger test done");
   endtask

   task automatic tAuto();
      logic [31:0] v;
      trq.delete();
      wr(ta(5, REG_VALUE), tv(0, 0, 0, 40));
      wr(ta(5, REG_TRIG), tv(0, 0, 0, 42));
      wr(ta(5, REG_MSG), 32'h21);
      wr(ta(5, REG_CTRL), 32'hf3);
      waitTrig(2);
      check("restart request", 32'(trq[1]), 32'h521);
      rd(ta(5, REG_CTRL), v);
      check("restart ctrl", v & 32'hf1, 32'h51);
      rd(ta(5, REG_VALUE), v);
      check("restart from zero", 32'(v <= tv(0, 0, 0, 2)), 32'h1);
      $display("auto restart test done");
   endtask

   task automatic tReset();
      logic [31:0] v;
      wr(ta(6, REG_VALUE), tv(1, 2, 3, 4));
      wr(ta(6, REG_CTRL), 32'h300);
      wr(ta(7, REG_VALUE), tv(1, 2, 3, 4));
      wr(ta(7, REG_CTRL), 32'h3);
      wr(ta(8, REG_CTRL), 32'h303);
      doReset();
      rd(ta(6, REG_VALUE), v);
      check("kept value", v, tv(1, 2, 3, 4));
      rd(ta(7, REG_VALUE), v);
      check("cleared value", v, 32'h0);
      rd(ta(7, REG_CTRL), v);
      check("cleared ctrl", v, 32'h0);
      rd(ta(8, REG_CTRL), v);
      check("kept running", v, 32'h101);
      rd(ta(8, REG_VALUE), v);
      waitChange(ta(8, REG_VALUE), v, v);
      $display("reset test done");
   endtask

   task automatic tBus();
      logic [31:0] v;
      logic e;
      apb(1'b0, 12'h420, 32'h0, v, e);
      check("unmapped error", 32'(e), 32'h1);
      check("unmapped data", v, 32'h0);
      apb(1'b1, ta(9, 12'h006), 32'h1234, v, e);
      check("misaligned error", 32'(e), 32'h1);
      rd(ta(9, REG_VALUE), v);
      check("ignored write", v, 32'h0);
      $display("bus test done");
   endtask

   // keep bits start unknown, so clear them all and reset once more
   initial
   begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < NUM_TIMERS; i++) wr(ta(i, REG_CTRL), 32'h200);
      doReset();
      tPreset();
      tWrap();
      tTrig();
      tAuto();
      tReset();
      tBus();
      results();
   end
endmodule
